// File: hdl/amer_pkg.sv
// package: register map, error word layout and timing constants of the analog error reporter
package amer_pkg;
	// ************************************************************
	// register offsets (byte addresses on apb)
	// ************************************************************
	localparam logic [7:0] AMER_ERR_WORD_OFS = 8'h00;
	localparam logic [7:0] AMER_CFG_OFS = 8'h04;
	localparam logic [7:0] AMER_IRQ_STAT_OFS = 8'h08;
	localparam logic [7:0] AMER_IRQ_MASK_OFS = 8'h0C;
	localparam logic [7:0] AMER_CHAN_STAT_OFS = 8'h10;
	localparam logic [7:0] AMER_CTRL_OFS = 8'h14;
	localparam logic [7:0] AMER_OUT0_OFS = 8'h18;
	localparam logic [7:0] AMER_OUT1_OFS = 8'h1C;
	localparam logic [7:0] AMER_OUT_STAT_OFS = 8'h20;
	// ************************************************************
	// error word fields
	// ************************************************************
	localparam int AMER_CLASS_LSB = 9;
	localparam int AMER_CLASS_W = 3;
	localparam int AMER_EXT_W = 9;
	localparam logic [2:0] AMER_CLASS_NONE = 3'h0;
	localparam logic [2:0] AMER_CLASS_HW = 3'h1;
	localparam logic [2:0] AMER_CLASS_CFG = 3'h2;
	localparam logic [8:0] AMER_EXT_ZERO = 9'h000;
	localparam logic [8:0] AMER_EXT_HW_GENERAL = 9'h000;
	localparam logic [8:0] AMER_EXT_HW_POWERUP = 9'h001;
	localparam logic [8:0] AMER_EXT_HW_SELFTEST = 9'h010;
	localparam logic [3:0] AMER_DONT_CARE = 4'h0;
	// ************************************************************
	// configuration layout: per channel 2 bits range, 2 bits filter, 2 bits format
	// ************************************************************
	localparam int AMER_CHANS = 4;
	localparam int AMER_OPT_W = 2;
	localparam logic [1:0] AMER_OPT_INVALID = 2'h3;
	localparam logic [23:0] AMER_CFG_RESET = 24'h000000;
	// ************************************************************
	// irq bits, ctrl bits, output data width
	// ************************************************************
	localparam int AMER_IRQ_HW = 0;
	localparam int AMER_IRQ_CFG = 1;
	localparam int AMER_IRQ_RANGE = 2;
	localparam int AMER_IRQ_W = 3;
	localparam int AMER_CTRL_CRIT = 0;
	localparam int AMER_DATA_W = 16;
	// ************************************************************
	// self test timing
	// ************************************************************
	localparam int AMER_CLK_MHZ = 100;
	localparam int AMER_SELFTEST_US = 10;
	localparam int AMER_SELFTEST_CYC = AMER_SELFTEST_US * AMER_CLK_MHZ;
	typedef enum logic [1:0] {
		AMER_ST_RESET = 2'b00,
		AMER_ST_TEST = 2'b01,
		AMER_ST_RUN = 2'b10,
		AMER_ST_FAULT = 2'b11
	} amer_state_t;
endpackage

// File: hdl/amer_core.sv
// file: the whole error reporting block with its apb slave
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - bits 15..12 of error word read zero
// - class field sits in bits 11..9
// - no error gives class 000
// - hardware fault gives class 001 plus code
// - configuration fault gives class 010 plus option
// - no error forces extended field to zero
// - hardware error reads as hex digit 2
// - bad configuration rejected, old one kept
// - any fault forces analog outputs to zero
// - range errors go to channel status
// - hardware and config faults reach the host
// - self test runs after power up
// - status indicator on in run mode unless a hardware error stands
// - hardware class with zero code is general
// - config codes count per channel and option
module amer_core import amer_pkg::*; #(
	parameter int SELFTEST_CYCLES = AMER_SELFTEST_CYC
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic selftest_fail_i,
	input wire logic hw_fault_i,
	input wire logic [AMER_CHANS-1:0] over_range_i,
	input wire logic [AMER_CHANS-1:0] under_range_i,
	output logic [AMER_DATA_W-1:0] analog_out0_o,
	output logic [AMER_DATA_W-1:0] analog_out1_o,
	output logic status_led_o,
	output logic irq_o
);
	// ************************************************************
	// pin synchronisers
	// ************************************************************
	localparam int SW = 2 + 2 * AMER_CHANS;
	logic [SW-1:0] sync1_reg;
	logic [SW-1:0] sync2_reg;
	// pins move with no relation to clk_i, so only the second stage is read
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= {selftest_fail_i, hw_fault_i, over_range_i, under_range_i};
			sync2_reg <= sync1_reg;
		end
	end
	logic st_fail;
	logic hw_flt;
	logic [AMER_CHANS-1:0] ovr;
	logic [AMER_CHANS-1:0] und;
	assign {st_fail, hw_flt, ovr, und} = sync2_reg;

	// ************************************************************
	// register state
	// ************************************************************
	amer_state_t state_reg, state_next;
	logic [31:0] cnt_reg, cnt_next;
	logic [2:0] class_reg, class_next;
	logic [8:0] ext_reg, ext_next;
	logic [23:0] cfg_reg, cfg_next;
	logic [AMER_IRQ_W-1:0] irq_stat_reg, irq_stat_next;
	logic [AMER_IRQ_W-1:0] irq_mask_reg, irq_mask_next;
	logic [2*AMER_CHANS-1:0] chan_reg, chan_next;
	logic crit_reg, crit_next;
	logic [AMER_DATA_W-1:0] out0_reg, out0_next;
	logic [AMER_DATA_W-1:0] out1_reg, out1_next;
	logic [AMER_DATA_W-1:0] dac0_reg, dac0_next;
	logic [AMER_DATA_W-1:0] dac1_reg, dac1_next;
	logic led_reg, led_next;
	logic irq_reg, irq_next;
	logic [31:0] rdata_reg, rdata_next;
	logic ready_reg, ready_next;
	logic err_reg, err_next;

	// ************************************************************
	// helpers
	// ************************************************************
	logic wr_setup;
	logic rd_setup;
	logic bad_cfg;
	logic [8:0] bad_code;
	logic fault;
	logic [15:0] err_word;
	logic addr_ok;
	// setup-phase strobes; fault also covers a standing configuration error
	assign wr_setup = psel_i && !penable_i && pwrite_i;
	assign rd_setup = psel_i && !penable_i && !pwrite_i;
	assign fault = (state_reg == AMER_ST_FAULT) || (class_reg != AMER_CLASS_NONE);
	assign err_word = {AMER_DONT_CARE, class_reg, ext_reg};

	// first invalid option in a written configuration, counted channel then option
	always_comb begin
		bad_cfg = 1'b0;
		bad_code = AMER_EXT_ZERO;
		// walking down from the top lets the lowest code overwrite the others
		for (int o = 2; o >= 0; o--) begin
			for (int c = AMER_CHANS - 1; c >= 0; c--) begin
				if (pwdata_i[(o*AMER_CHANS+c)*AMER_OPT_W +: AMER_OPT_W] == AMER_OPT_INVALID) begin
					bad_cfg = 1'b1;
					bad_code = 9'((o * AMER_CHANS) + c + 1);
				end
			end
		end
	end

	// mapped offsets; anything else is answered with pslverr and no effect
	always_comb begin
		unique case (paddr_i)
			AMER_ERR_WORD_OFS, AMER_CFG_OFS, AMER_IRQ_STAT_OFS, AMER_IRQ_MASK_OFS,
			AMER_CHAN_STAT_OFS, AMER_CTRL_OFS, AMER_OUT0_OFS, AMER_OUT1_OFS,
			AMER_OUT_STAT_OFS: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end

	// ************************************************************
	// next state: diagnostics, configuration, bus
	// ************************************************************
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		class_next = class_reg;
		ext_next = ext_reg;
		cfg_next = cfg_reg;
		irq_stat_next = irq_stat_reg;
		irq_mask_next = irq_mask_reg;
		crit_next = crit_reg;
		out0_next = out0_reg;
		out1_next = out1_reg;
		rdata_next = rdata_reg;
		ready_next = 1'b0;
		err_next = 1'b0;
		chan_next = {ovr, und};
		// power-up self test then run, hardware faults latch until reset
		unique case (state_reg)
			AMER_ST_RESET: begin
				class_next = AMER_CLASS_HW;
				ext_next = AMER_EXT_HW_POWERUP;
				cnt_next = '0;
				state_next = AMER_ST_TEST;
			end
			AMER_ST_TEST: begin
				cnt_next = cnt_reg + 32'h00000001;
				if (st_fail) begin
					state_next = AMER_ST_FAULT;
					class_next = AMER_CLASS_HW;
					ext_next = AMER_EXT_HW_SELFTEST;
				end else if (cnt_reg >= 32'(SELFTEST_CYCLES - 1)) begin
					state_next = AMER_ST_RUN;
					class_next = AMER_CLASS_NONE;
					ext_next = AMER_EXT_ZERO;
				end
			end
			AMER_ST_RUN: begin
				if (hw_flt) begin
					state_next = AMER_ST_FAULT;
					class_next = AMER_CLASS_HW;
					ext_next = AMER_EXT_HW_GENERAL;
				end
			end
			AMER_ST_FAULT: begin
				// only nrst_i leaves here, so a hardware error survives bus traffic
				state_next = AMER_ST_FAULT;
			end
		endcase
		// setup-phase decode, answer one cycle later
		if (psel_i && !penable_i) begin
			ready_next = 1'b1;
			err_next = !addr_ok;
		end
		if (wr_setup && addr_ok) begin
			unique case (paddr_i)
				AMER_CFG_OFS: begin
					if (bad_cfg) begin
						// a standing hardware error must not be hidden by a config error
						if (state_next == AMER_ST_RUN && class_reg != AMER_CLASS_HW) begin
							class_next = AMER_CLASS_CFG;
							ext_next = bad_code;
						end
					end else begin
						cfg_next = pwdata_i[23:0];
						if (class_reg == AMER_CLASS_CFG) begin
							class_next = AMER_CLASS_NONE;
							ext_next = AMER_EXT_ZERO;
						end
					end
				end
				AMER_IRQ_MASK_OFS: irq_mask_next = pwdata_i[AMER_IRQ_W-1:0];
				AMER_CTRL_OFS: crit_next = pwdata_i[AMER_CTRL_CRIT];
				AMER_OUT0_OFS: out0_next = pwdata_i[AMER_DATA_W-1:0];
				AMER_OUT1_OFS: out1_next = pwdata_i[AMER_DATA_W-1:0];
				default: ;
			endcase
		end
		if (rd_setup) begin
			unique case (paddr_i)
				AMER_ERR_WORD_OFS: rdata_next = {16'h0000, err_word};
				AMER_CFG_OFS: rdata_next = {8'h00, cfg_reg};
				AMER_IRQ_STAT_OFS: rdata_next = {29'h00000000, irq_stat_reg};
				AMER_IRQ_MASK_OFS: rdata_next = {29'h00000000, irq_mask_reg};
				AMER_CHAN_STAT_OFS: rdata_next = {24'h000000, chan_reg};
				AMER_CTRL_OFS: rdata_next = {31'h00000000, crit_reg};
				AMER_OUT0_OFS: rdata_next = {16'h0000, out0_reg};
				AMER_OUT1_OFS: rdata_next = {16'h0000, out1_reg};
				AMER_OUT_STAT_OFS: rdata_next = {dac1_reg, dac0_reg};
				default: rdata_next = 32'h00000000;
			endcase
			if (paddr_i == AMER_IRQ_STAT_OFS) begin
				irq_stat_next = '0; // read clears
			end
		end
		// events set sticky bits, set wins over the read clear
		// a failed self test keeps class 001, so entering the fault state is the event
		if (state_next == AMER_ST_FAULT && state_reg != AMER_ST_FAULT)
			irq_stat_next[AMER_IRQ_HW] = 1'b1;
		if (class_next == AMER_CLASS_CFG && ext_next != ext_reg)
			irq_stat_next[AMER_IRQ_CFG] = 1'b1;
		if (|chan_next && !(|chan_reg))
			irq_stat_next[AMER_IRQ_RANGE] = 1'b1;
	end

	// output side: faults zero the converters, indicator on in run mode without a hardware error
	always_comb begin
		// converters follow the setpoints one cycle late, after the fault check
		if (fault || state_reg != AMER_ST_RUN) begin
			dac0_next = '0;
			dac1_next = '0;
		end else begin
			dac0_next = out0_reg;
			dac1_next = out1_reg;
		end
		led_next = (state_next == AMER_ST_RUN) && (class_next != AMER_CLASS_HW);
		irq_next = |(irq_stat_next & irq_mask_next);
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_reg <= AMER_ST_RESET;
			cnt_reg <= '0;
			class_reg <= AMER_CLASS_HW;
			ext_reg <= AMER_EXT_HW_POWERUP;
			cfg_reg <= AMER_CFG_RESET;
			irq_stat_reg <= '0;
			irq_mask_reg <= '0;
			chan_reg <= '0;
			crit_reg <= 1'b0;
			out0_reg <= '0;
			out1_reg <= '0;
			dac0_reg <= '0;
			dac1_reg <= '0;
			led_reg <= 1'b0;
			irq_reg <= 1'b0;
			rdata_reg <= '0;
			ready_reg <= 1'b0;
			err_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			class_reg <= class_next;
			ext_reg <= ext_next;
			cfg_reg <= cfg_next;
			irq_stat_reg <= irq_stat_next;
			irq_mask_reg <= irq_mask_next;
			chan_reg <= chan_next;
			crit_reg <= crit_next;
			out0_reg <= out0_next;
			out1_reg <= out1_next;
			dac0_reg <= dac0_next;
			dac1_reg <= dac1_next;
			led_reg <= led_next;
			irq_reg <= irq_next;
			rdata_reg <= rdata_next;
			ready_reg <= ready_next;
			err_reg <= err_next;
		end
	end

	assign prdata_o = rdata_reg;
	assign pready_o = ready_reg;
	assign pslverr_o = err_reg;
	assign analog_out0_o = dac0_reg;
	assign analog_out1_o = dac1_reg;
	assign status_led_o = led_reg;
	assign irq_o = irq_reg;
endmodule
`default_nettype wire

// File: verification/amer_core_asserts.sv
// checker: concurrent properties on the ports of the error reporter
`timescale 1ns/100ps
`default_nettype none
module amer_core_asserts import amer_pkg::*; #(
	parameter int SELFTEST_CYCLES = AMER_SELFTEST_CYC
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic hw_fault_i,
	input wire logic [AMER_DATA_W-1:0] analog_out0_o,
	input wire logic [AMER_DATA_W-1:0] analog_out1_o,
	input wire logic status_led_o
);
	// ****
	// helper logic and properties
	// ****
	int cyc_reg;
	logic ew_rd;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	// completed read of the error word
	assign ew_rd = psel_i && penable_i && pready_o && !pwrite_i && paddr_i == AMER_ERR_WORD_OFS;
	// edges since reset release, saturating at the self test length
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			cyc_reg <= 0;
		else if (cyc_reg < SELFTEST_CYCLES)
			cyc_reg <= cyc_reg + 1;
	end
	property p_dont_care; ew_rd |-> prdata_o[31:12] == 20'h00000; endproperty
	a_dont_care: assert property (p_dont_care) else $error("error word top bits set");
	property p_class; ew_rd |-> prdata_o[11:9] <= AMER_CLASS_CFG; endproperty
	a_class: assert property (p_class) else $error("undefined error class");
	property p_ext_zero;
		ew_rd && prdata_o[11:9] == AMER_CLASS_NONE |-> prdata_o[8:0] == AMER_EXT_ZERO;
	endproperty
	a_ext_zero: assert property (p_ext_zero) else $error("extended field not zero");
	property p_fault_out;
		$rose(hw_fault_i) |-> ##[1:6] (analog_out0_o == 16'h0000 && analog_out1_o == 16'h0000);
	endproperty
	a_fault_out: assert property (p_fault_out) else $error("outputs not zeroed");
	property p_fault_led; $rose(hw_fault_i) ##6 1 |-> !status_led_o [*4]; endproperty
	a_fault_led: assert property (p_fault_led) else $error("indicator on in fault");
	property p_selftest; cyc_reg < SELFTEST_CYCLES |-> !status_led_o; endproperty
	a_selftest: assert property (p_selftest) else $error("indicator on in self test");
	property p_answer; psel_i && !penable_i |=> pready_o; endproperty
	a_answer: assert property (p_answer) else $error("no ready in access phase");
	property p_ready_acc; pready_o |-> psel_i && penable_i; endproperty
	a_ready_acc: assert property (p_ready_acc) else $error("ready outside access");
	property p_err_rdy; pslverr_o |-> pready_o; endproperty
	a_err_rdy: assert property (p_err_rdy) else $error("slave error without ready");
endmodule
bind amer_core amer_core_asserts #(.SELFTEST_CYCLES(SELFTEST_CYCLES)) u_chk (
	.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
	.pslverr_o(pslverr_o), .hw_fault_i(hw_fault_i), .analog_out0_o(analog_out0_o),
	.analog_out1_o(analog_out1_o), .status_led_o(status_led_o));
`default_nettype wire

// File: verification/amer_host.sv
// host model: apb master and run mode of the controller
`timescale 1ns/100ps
`default_nettype none
module amer_host import amer_pkg::*; (
	input wire logic clk_i,
	output logic psel_o,
	output logic penable_o,
	output logic pwrite_o,
	output logic [7:0] paddr_o,
	output logic [31:0] pwdata_o,
	input wire logic [31:0] prdata_i,
	input wire logic pready_i,
	input wire logic pslverr_i
);
	// ****
	// bus cycles
	// ****
	logic run_mode = 1'b1;
	logic [31:0] rq;
	logic eq;
	// idle bus at time zero
	initial begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 8'h00;
		pwdata_o = 32'h00000000;
	end
	// setup, then access held until ready is sampled high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clk_i);
		psel_o <= 1'b1;
		penable_o <= 1'b0;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= d;
		@(posedge clk_i);
		penable_o <= 1'b1;
		@(posedge clk_i);
		while (pready_i !== 1'b1)
			@(posedge clk_i);
		r = prdata_i;
		e = pslverr_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		pwdata_o <= ~d; // released data does not hold its value
	endtask
	// extended field is only looked at under a nonzero class
	task automatic rd_err(output logic [2:0] c, output logic [8:0] x);
		xfer(1'b0, AMER_ERR_WORD_OFS, 32'h0, rq, eq);
		c = rq[11:9];
		x = (c != AMER_CLASS_NONE) ? rq[8:0] : AMER_EXT_ZERO;
	endtask
	// critical error: leave run mode and flag it
	task automatic crit();
		run_mode = 1'b0;
		xfer(1'b1, AMER_CTRL_OFS, 32'h1, rq, eq);
	endtask
endmodule
`default_nettype wire

// File: verification/testbench.sv
// testbench: scenarios for the error reporter over apb
`timescale 1ns/100ps
`default_nettype none
module testbench import amer_pkg::*; ();
	// ****
	// signals, instances, shared tasks
	// ****
	localparam int ST = 8;
	logic clk_i = 1'b0, nrst_i = 1'b0, stf = 1'b0, hwf = 1'b0, e;
	logic psel, pen, pwr, prdy, perr, led, irq;
	logic [3:0] ovr = 4'h0, und = 4'h0;
	logic [7:0] pa;
	logic [31:0] pwd, prd, r;
	logic [15:0] ao0, ao1;
	logic [2:0] cl;
	logic [8:0] ex;
	int err_count = 0, n_tests = 0;
	amer_core #(.SELFTEST_CYCLES(ST)) dut (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel),
		.penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd),
		.pready_o(prdy), .pslverr_o(perr), .selftest_fail_i(stf), .hw_fault_i(hwf),
		.over_range_i(ovr), .under_range_i(und), .analog_out0_o(ao0), .analog_out1_o(ao1),
		.status_led_o(led), .irq_o(irq));
	amer_host host (.clk_i(clk_i), .psel_o(psel), .penable_o(pen), .pwrite_o(pwr),
		.paddr_o(pa), .pwdata_o(pwd), .prdata_i(prd), .pready_i(prdy), .pslverr_i(perr));
	// 100 mhz clock
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		host.xfer(1'b0, a, 32'h0, r, e);
		chk(r, exp);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d, r, e);
	endtask
	task automatic do_reset();
		nrst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		nrst_i <= 1'b1;
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_power();
		rd(AMER_ERR_WORD_OFS, 32'h0201);
		chk({31'h0, led}, 32'h0);
		repeat (ST + 4) @(posedge clk_i);
		rd(AMER_ERR_WORD_OFS, 32'h0000);
		chk({31'h0, led}, 32'h1);
	endtask
	task automatic t_cfg();
		logic [31:0] bad [4] = '{32'h0000000C, 32'h0000C000, 32'h00030000, 32'h0003000C};
		logic [8:0] code [4] = '{9'h002, 9'h008, 9'h009, 9'h002};
		host.xfer(1'b0, 8'h24, 32'h0, r, e);
		chk({31'h0, e}, 32'h1);
		wr(AMER_IRQ_MASK_OFS, 32'h2);
		wr(AMER_CFG_OFS, 32'h11);
		foreach (bad[i]) begin
			wr(AMER_CFG_OFS, bad[i]);
			rd(AMER_ERR_WORD_OFS, {20'h0, AMER_CLASS_CFG, code[i]});
			rd(AMER_CFG_OFS, 32'h11);
		end
		chk({31'h0, irq}, 32'h1);
		wr(AMER_CFG_OFS, 32'h11);
		rd(AMER_ERR_WORD_OFS, 32'h0);
		rd(AMER_IRQ_STAT_OFS, 32'h2);
		repeat (2) @(posedge clk_i);
		#1;
		chk({31'h0, irq}, 32'h0);
	endtask
	task automatic t_range();
		@(posedge clk_i);
		ovr <= 4'h4;
		repeat (5) @(posedge clk_i);
		rd(AMER_CHAN_STAT_OFS, 32'h40);
		rd(AMER_ERR_WORD_OFS, 32'h0);
		chk({31'h0, irq}, 32'h0);
		rd(AMER_IRQ_STAT_OFS, 32'h4);
		ovr <= 4'h0;
		und <= 4'h1;
		repeat (5) @(posedge clk_i);
		rd(AMER_CHAN_STAT_OFS, 32'h01);
	endtask
	task automatic t_hw();
		wr(AMER_OUT0_OFS, 32'h1234);
		wr(AMER_OUT1_OFS, 32'hABCD);
		rd(AMER_OUT_STAT_OFS, 32'hABCD1234);
		hwf <= 1'b1;
		repeat (5) @(posedge clk_i);
		#1;
		chk({ao1, ao0}, 32'h0);
		chk({31'h0, led}, 32'h0);
		host.rd_err(cl, ex);
		chk({20'h0, cl, ex}, 32'h0200);
		rd(AMER_IRQ_STAT_OFS, 32'h1);
		host.crit();
		chk({31'h0, host.run_mode}, 32'h0);
		rd(AMER_CTRL_OFS, 32'h1);
		hwf <= 1'b0;
	endtask
	task automatic t_stfail();
		stf <= 1'b1;
		do_reset();
		repeat (ST + 6) @(posedge clk_i);
		rd(AMER_ERR_WORD_OFS, 32'h0210);
		rd(AMER_IRQ_STAT_OFS, 32'h5);
		chk({31'h0, led}, 32'h0);
	endtask
	task automatic tally_and_finish();
		$display("mismatches %0d comparisons %0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		do_reset();
		t_power();
		t_cfg();
		t_range();
		t_hw();
		t_stfail();
		tally_and_finish();
	end
	// watchdog against a hung handshake
	initial begin
		repeat (5000) @(posedge clk_i);
		err_count++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
